// ==== hdl/dram_ctrl_regs.vh ====
// timing constants and cycle counts for the page-mode dram controller
`ifndef DRAM_CTRL_REGS_VH
`define DRAM_CTRL_REGS_VH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 5000

// ----------------------------------------------------------------
// printed times, in ps, ns or us as each name says, and derived cycle counts
// ----------------------------------------------------------------
`define POWERUP_WAIT_NS 200000
`define POWERUP_WAIT_CYC ((`POWERUP_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define IDLE_LIMIT_US 16000
`define IDLE_LIMIT_CYC (`IDLE_LIMIT_US * (1000000 / `CLK_PERIOD_PS))
`define ROW_INTERVAL_PS 15600000
`define ROW_INTERVAL_CYC (`ROW_INTERVAL_PS / `CLK_PERIOD_PS)
`define WAKE_CYCLES 8
`define ROW_COUNT 1024
`define ROW_TO_COL_PS 20000
`define ROW_TO_COL_CYC ((`ROW_TO_COL_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ROW_ACTIVE_PS 75000
`define ROW_ACTIVE_CYC ((`ROW_ACTIVE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define COL_ACTIVE_PS 25000
`define COL_ACTIVE_CYC ((`COL_ACTIVE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ROW_PRECHARGE_PS 55000
`define ROW_PRECHARGE_CYC ((`ROW_PRECHARGE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define COL_PRECHARGE_PS 10000
`define COL_PRECHARGE_CYC ((`COL_PRECHARGE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_LEAD_PS 20000
`define WRITE_LEAD_CYC ((`WRITE_LEAD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define COL_TO_WRITE_PS 50000
`define COL_TO_WRITE_CYC ((`COL_TO_WRITE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define OE_HOLD_PS 20000
`define OE_HOLD_CYC ((`OE_HOLD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PAGE_ROW_MAX_PS 200000000
`define PAGE_ROW_MAX_CYC (`PAGE_ROW_MAX_PS / `CLK_PERIOD_PS)
`define DATA_HOLD_PS 15000
`define DATA_HOLD_CYC ((`DATA_HOLD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// ----------------------------------------------------------------
// command encodings
// ----------------------------------------------------------------
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_LATE_WRITE 2'h2
`define OP_READ_WRITE 2'h3

`endif

// ==== hdl/down_timer.v ====
// loadable down-counter used for the power-up wait and refresh scheduling
module down_timer #(
    parameter WIDTH = 16
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    input wire i_load,
    input wire [WIDTH-1:0] i_value,
    output wire o_zero
);
    reg [WIDTH-1:0] count_q;

    // load wins over the count; holds at zero
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count_q <= {WIDTH{1'b0}};
        end else if (i_ce) begin
            if (i_load) begin
                count_q <= i_value;
            end else if (count_q != {WIDTH{1'b0}}) begin
                count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    assign o_zero = (count_q == {WIDTH{1'b0}});
endmodule // down_timer

// ==== hdl/dram_page_ctrl.v ====
// controller driving a multiplexed-address page-mode dram through its pins
`include "dram_ctrl_regs.vh"
module dram_page_ctrl #(
    parameter POWERUP_CYC = `POWERUP_WAIT_CYC,
    parameter IDLE_CYC = `IDLE_LIMIT_CYC,
    parameter REFRESH_CYC = `ROW_INTERVAL_CYC,
    parameter PAGE_MAX_CYC = `PAGE_ROW_MAX_CYC
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    // user request: one access per handshake
    input wire i_req_valid,
    output wire o_req_ready,
    input wire [1:0] i_req_op,
    input wire [19:0] i_req_addr,
    input wire [3:0] i_req_wdata,
    output reg [3:0] o_rdata,
    output reg o_rdata_valid,
    output wire o_init_done,
    // dram pins
    output reg o_row_strobe_n,
    output reg o_col_strobe_n,
    output reg o_write_n,
    output reg o_out_enable_n,
    output reg [9:0] o_muxed_address_lines,
    input wire [3:0] i_data_lines,
    output reg [3:0] o_data_lines,
    output reg o_data_lines_oe
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [3:0] S_POWER = 4'h0;
    localparam [3:0] S_WAKE_ACT = 4'h1;
    localparam [3:0] S_WAKE_PRE = 4'h2;
    localparam [3:0] S_IDLE = 4'h3;
    localparam [3:0] S_ROW = 4'h4;
    localparam [3:0] S_COL = 4'h5;
    localparam [3:0] S_LATE = 4'h6;
    localparam [3:0] S_COL_PRE = 4'h7;
    localparam [3:0] S_ROW_END = 4'h8;
    localparam [3:0] S_PRE = 4'h9;
    localparam [3:0] S_REF_ACT = 4'ha;

    localparam [31:0] T_RCD = `ROW_TO_COL_CYC;
    localparam [31:0] T_RAS = `ROW_ACTIVE_CYC;
    localparam [31:0] T_CAS = `COL_ACTIVE_CYC;
    localparam [31:0] T_RP = `ROW_PRECHARGE_CYC;
    localparam [31:0] T_CP = `COL_PRECHARGE_CYC;
    localparam [31:0] T_WL = `WRITE_LEAD_CYC;
    localparam [31:0] T_CWD = `COL_TO_WRITE_CYC;
    localparam [31:0] T_DH = `DATA_HOLD_CYC;
    localparam [31:0] P_CYC = PAGE_MAX_CYC;
    localparam [31:0] U_CYC = POWERUP_CYC;
    localparam [31:0] R_CYC = REFRESH_CYC;
    localparam [31:0] I_CYC = IDLE_CYC;

    reg [3:0] state_q;
    reg [3:0] wake_cnt_q;
    reg [9:0] ref_row_q;
    reg [9:0] open_row_q;
    reg [1:0] op_q;
    reg [3:0] wdata_q;
    reg [7:0] step_q;
    reg [7:0] ras_age_q;
    reg [25:0] page_age_q;
    reg [31:0] idle_q;
    reg init_done_q;
    reg ref_pending_q;
    reg [3:0] din_s1_q;
    reg [3:0] din_s2_q;
    reg [9:0] col_addr_q;

    // ----------------------------------------------------------------
    // power-up wait and refresh scheduling timers
    // ----------------------------------------------------------------
    wire power_zero;
    wire ref_zero;
    reg power_load_q;
    reg ref_load;

    // long wait of the power-up pause, loaded once after reset
    down_timer #(.WIDTH(32)) u_power (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_load(power_load_q),
        .i_value(U_CYC),
        .o_zero(power_zero)
    );

    // one row refresh per interval; reload on each expiry
    down_timer #(.WIDTH(32)) u_refresh (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_load(ref_load),
        .i_value(R_CYC),
        .o_zero(ref_zero)
    );

    always @* begin
        ref_load = ref_zero & init_done_q;
    end

    // ----------------------------------------------------------------
    // data pin synchroniser
    // ----------------------------------------------------------------
    // read data comes from off-chip, so two stages before use
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            din_s1_q <= 4'h0;
            din_s2_q <= 4'h0;
        end else if (i_ce) begin
            din_s1_q <= i_data_lines;
            din_s2_q <= din_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // handshake
    // ----------------------------------------------------------------
    // a pending refresh outranks user traffic at the page boundary
    wire page_full = (page_age_q >= P_CYC[25:0] - 26'h40);
    // no handshake in the cycle that starts a wakeup, or it would be lost
    wire wake_due = init_done_q & (idle_q >= I_CYC);
    wire can_take = init_done_q & ~ref_pending_q & ~wake_due;
    wire same_row = (i_req_addr[19:10] == open_row_q) & ~page_full;
    assign o_req_ready = i_ce & can_take &
        ((state_q == S_IDLE) | ((state_q == S_COL_PRE) &
        (step_q == 8'h00) & same_row));
    assign o_init_done = init_done_q;
    wire take = i_req_valid & o_req_ready;

    // ----------------------------------------------------------------
    // main sequencer
    // ----------------------------------------------------------------
    // step_q counts down the current phase; one cycle is 5 ns
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= S_POWER;
            wake_cnt_q <= 4'h0;
            ref_row_q <= 10'h000;
            open_row_q <= 10'h000;
            op_q <= `OP_READ;
            wdata_q <= 4'h0;
            step_q <= 8'h00;
            ras_age_q <= 8'h00;
            page_age_q <= 26'h0;
            idle_q <= 32'h0;
            init_done_q <= 1'b0;
            ref_pending_q <= 1'b0;
            power_load_q <= 1'b1;
            o_row_strobe_n <= 1'b1;
            o_col_strobe_n <= 1'b1;
            o_write_n <= 1'b1;
            o_out_enable_n <= 1'b1;
            o_muxed_address_lines <= 10'h000;
            o_data_lines <= 4'h0;
            o_data_lines_oe <= 1'b0;
            o_rdata <= 4'h0;
            o_rdata_valid <= 1'b0;
        end else if (i_ce) begin
            power_load_q <= 1'b0;
            o_rdata_valid <= 1'b0;
            if (step_q != 8'h00) begin
                step_q <= step_q - 8'h01;
            end
            if (ras_age_q != 8'hff) begin
                ras_age_q <= ras_age_q + 8'h01;
            end
            if (!o_row_strobe_n) begin
                page_age_q <= page_age_q + 26'h1;
            end
            // set wins: an expiry in a serviced cycle stays pending
            if (ref_load) begin
                ref_pending_q <= 1'b1;
            end
            // quiet time in idle; the idle branch acts once it is due
            if (o_row_strobe_n && init_done_q && state_q == S_IDLE &&
                    !wake_due) begin
                idle_q <= idle_q + 32'h1;
            end
            case (state_q)
                S_POWER: begin
                    // all pins quiet until the bias has settled
                    if (!power_load_q && power_zero) begin
                        state_q <= S_WAKE_PRE;
                        step_q <= T_RP[7:0];
                    end
                end
                S_WAKE_PRE: begin
                    if (step_q == 8'h00) begin
                        if (wake_cnt_q == `WAKE_CYCLES) begin
                            init_done_q <= 1'b1;
                            idle_q <= 32'h0;
                            state_q <= S_IDLE;
                        end else begin
                            // row-only cycle doubles as a refresh
                            o_muxed_address_lines <= ref_row_q;
                            ref_row_q <= ref_row_q + 10'h001;
                            o_row_strobe_n <= 1'b0;
                            step_q <= T_RAS[7:0];
                            state_q <= S_WAKE_ACT;
                        end
                    end
                end
                S_WAKE_ACT: begin
                    if (step_q == 8'h00) begin
                        o_row_strobe_n <= 1'b1;
                        wake_cnt_q <= wake_cnt_q + 4'h1;
                        step_q <= T_RP[7:0];
                        state_q <= S_WAKE_PRE;
                    end
                end
                S_IDLE: begin
                    if (wake_due) begin
                        // idle too long: rerun the eight wakeup cycles
                        init_done_q <= 1'b0;
                        wake_cnt_q <= 4'h0;
                        idle_q <= 32'h0;
                        state_q <= S_WAKE_PRE;
                    end else if (ref_pending_q) begin
                        // row-only refresh: column strobe stays high, so
                        // neither cbr nor hidden refresh is ever entered
                        ref_pending_q <= ref_load;
                        o_muxed_address_lines <= ref_row_q;
                        ref_row_q <= ref_row_q + 10'h001;
                        o_row_strobe_n <= 1'b0;
                        o_col_strobe_n <= 1'b1;
                        step_q <= T_RAS[7:0];
                        idle_q <= 32'h0;
                        state_q <= S_REF_ACT;
                    end else if (take) begin
                        // row half on the shared pins in the same cycle as the row strobe
                        o_muxed_address_lines <= i_req_addr[19:10];
                        open_row_q <= i_req_addr[19:10];
                        op_q <= i_req_op;
                        wdata_q <= i_req_wdata;
                        o_row_strobe_n <= 1'b0;
                        ras_age_q <= 8'h00;
                        page_age_q <= 26'h0;
                        step_q <= T_RCD[7:0];
                        idle_q <= 32'h0;
                        state_q <= S_ROW;
                        // early write: enable low before column strobe
                        o_write_n <= (i_req_op != `OP_WRITE);
                        o_col_strobe_n <= 1'b1;
                        o_data_lines <= i_req_wdata;
                        o_data_lines_oe <= (i_req_op == `OP_WRITE);
                        o_out_enable_n <= ~((i_req_op == `OP_READ) |
                            (i_req_op == `OP_READ_WRITE));
                    end
                end
                S_ROW: begin
                    // column address on pins one phase ahead
                    o_muxed_address_lines <= col_addr_q;
                    if (step_q == 8'h00) begin
                        o_col_strobe_n <= 1'b0;
                        step_q <= (op_q == `OP_WRITE) ? T_WL[7:0] :
                            ((op_q == `OP_READ) ? T_CAS[7:0] :
                            T_CWD[7:0]);
                        state_q <= S_COL;
                    end
                end
                S_COL: begin
                    if (step_q == 8'h00) begin
                        if (op_q == `OP_READ) begin
                            // data taken through the synchroniser
                            o_rdata <= din_s2_q;
                            o_rdata_valid <= 1'b1;
                            o_col_strobe_n <= 1'b1;
                            o_out_enable_n <= 1'b1;
                            step_q <= T_CP[7:0];
                            state_q <= S_COL_PRE;
                        end else if (op_q == `OP_WRITE) begin
                            o_col_strobe_n <= 1'b1;
                            step_q <= T_CP[7:0];
                            state_q <= S_COL_PRE;
                        end else begin
                            // late or read-write: read-write grabs data, then both write
                            if (op_q == `OP_READ_WRITE) begin
                                o_rdata <= din_s2_q;
                                o_rdata_valid <= 1'b1;
                            end
                            o_out_enable_n <= 1'b1;
                            o_data_lines <= wdata_q;
                            o_data_lines_oe <= 1'b1;
                            o_write_n <= 1'b0;
                            step_q <= T_WL[7:0];
                            state_q <= S_LATE;
                        end
                    end
                end
                S_LATE: begin
                    // enable stays off and strobes held for write lead
                    if (step_q == 8'h00) begin
                        o_col_strobe_n <= 1'b1;
                        step_q <= T_CP[7:0];
                        state_q <= S_COL_PRE;
                    end
                end
                S_COL_PRE: begin
                    // hold write data and write level past the strobe
                    if (step_q + T_DH[7:0] <= T_CP[7:0] + 8'h01) begin
                        o_write_n <= 1'b1;
                        o_data_lines_oe <= 1'b0;
                    end
                    if (step_q == 8'h00) begin
                        if (take) begin
                            // next column on the open row
                            op_q <= i_req_op;
                            wdata_q <= i_req_wdata;
                            o_write_n <= (i_req_op != `OP_WRITE);
                            o_data_lines <= i_req_wdata;
                            o_data_lines_oe <= (i_req_op == `OP_WRITE);
                            o_out_enable_n <= ~((i_req_op == `OP_READ) |
                                (i_req_op == `OP_READ_WRITE));
                            o_muxed_address_lines <= i_req_addr[9:0];
                            step_q <= 8'h00;
                            state_q <= S_ROW;
                        end else if (ras_age_q >= T_RAS[7:0]) begin
                            // row rises after the column strobe already did
                            o_row_strobe_n <= 1'b1;
                            o_write_n <= 1'b1;
                            o_data_lines_oe <= 1'b0;
                            step_q <= T_RP[7:0];
                            state_q <= S_PRE;
                        end
                    end
                end
                S_REF_ACT: begin
                    if (step_q == 8'h00) begin
                        o_row_strobe_n <= 1'b1;
                        step_q <= T_RP[7:0];
                        state_q <= S_PRE;
                    end
                end
                S_PRE: begin
                    // precharge before any new active cycle
                    if (step_q == 8'h00) begin
                        idle_q <= 32'h0;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // column address capture
    // ----------------------------------------------------------------
    // request address is held only at the handshake, so keep column
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            col_addr_q <= 10'h000;
        end else if (i_ce && take) begin
            col_addr_q <= i_req_addr[9:0];
        end
    end
endmodule // dram_page_ctrl

// ==== bench/dram_model.sv ====
// behavioural page-mode dram answering the controller's strobes
module dram_model (
    input wire logic row_n,
    input wire logic col_n,
    input wire logic write_n,
    input wire logic oe_n,
    input wire logic [9:0] addr,
    input wire logic [3:0] d_ctrl,
    input wire logic d_oe,
    output wire logic [3:0] line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] mem [bit [19:0]];
    logic [9:0] row_q = 10'h0;
    logic [19:0] loc = 20'h0;
    logic [3:0] rd = 4'h0;
    logic [3:0] last = 4'h0;
    logic drv = 1'b0;
    logic wtog = 1'b0;
    // row latch; each activation refreshes the whole row
    always @(negedge row_n) begin
        #1;
        row_q = addr;
    end
    // column only counts once the row is in; early write data here
    always @(negedge col_n) begin
        #1;
        if (!row_n) begin
            loc = {row_q, addr};
            if (!write_n) begin
                mem[loc] = line;
                wtog = !wtog;
            end
        end
    end
    // late write and read-write take data at the write edge
    always @(negedge write_n) begin
        #1;
        if (!col_n && !row_n) begin
            mem[loc] = line;
            wtog = !wtog;
        end
    end
    // output only with column and enable active, write high
    always @(row_n, col_n, oe_n, write_n, loc, wtog) begin
        drv = !row_n && !col_n && !oe_n && write_n;
        rd = mem.exists(loc) ? mem[loc] : 4'h0;
        if (drv)
            last = rd;
    end
    // released bus shows the inverse, no pull on these lines
    assign line = d_oe ? d_ctrl : (drv ? rd : ~last);
endmodule // dram_model

// ==== bench/dram_page_ctrl_props.sv ====
// pin-level assertions for the page-mode dram controller
module dram_page_ctrl_props #(
    parameter POWERUP_CYC = 40000
) (
    input wire i_clk,
    input wire i_reset,
    input wire o_init_done,
    input wire o_row_strobe_n,
    input wire o_col_strobe_n,
    input wire o_write_n,
    input wire o_out_enable_n,
    input wire o_data_lines_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [3:0] hi_q;
    logic [3:0] wake_q;
    logic [31:0] up_q;
    // saturating counters: precharge length, row cycles; time up is free-running
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hi_q <= 4'hf;
            wake_q <= 4'h0;
            up_q <= 32'h0;
        end else begin
            hi_q <= !o_row_strobe_n ? 4'h0 : hi_q + {3'h0, hi_q != 4'hf};
            wake_q <= wake_q + {3'h0, $fell(o_row_strobe_n) && wake_q != 4'hf};
            up_q <= up_q + 32'h1;
        end
    end
    AST_PWR_WAIT: assert property (
        $fell(o_row_strobe_n) && wake_q == 4'h0 |-> up_q >= POWERUP_CYC)
        else $error("row strobe before power wait");
    AST_WAKE_COUNT: assert property (
        $rose(o_init_done) |-> wake_q >= 4'h8)
        else $error("init done before eight row cycles");
    AST_NO_COL_INIT: assert property (
        !o_init_done |-> o_col_strobe_n)
        else $error("column strobe during init");
    AST_ROW_BEFORE_COL: assert property (
        $fell(o_col_strobe_n)
        |-> !o_row_strobe_n && !$past(o_row_strobe_n, 4))
        else $error("column strobe too soon after row");
    AST_ROW_PRECHARGE: assert property (
        $fell(o_row_strobe_n) |-> hi_q >= 4'hb)
        else $error("row precharge short");
    AST_COL_WIDTH: assert property (
        $rose(o_col_strobe_n) |-> !$past(o_col_strobe_n, 5))
        else $error("column pulse short");
    AST_COL_PRECHARGE: assert property (
        $rose(o_col_strobe_n) |=> o_col_strobe_n)
        else $error("column precharge short");
    AST_PAGE_END: assert property (
        $rose(o_row_strobe_n) |-> o_col_strobe_n)
        else $error("row ended before column");
    AST_NO_CBR: assert property (
        $fell(o_row_strobe_n) |-> o_col_strobe_n)
        else $error("column strobe active at row start");
    AST_EARLY_WRITE: assert property (
        $fell(o_col_strobe_n) && !o_write_n
        |-> o_data_lines_oe && o_out_enable_n)
        else $error("early write bus");
    AST_OE_HOLD: assert property (
        $fell(o_write_n) |-> o_out_enable_n [*4])
        else $error("output enable not held off");
    AST_WRITE_LEAD: assert property (
        $rose(o_col_strobe_n) && !$past(o_write_n)
        |-> !$past(o_write_n, 4))
        else $error("write lead short");
endmodule // dram_page_ctrl_props

bind dram_page_ctrl dram_page_ctrl_props #(.POWERUP_CYC(POWERUP_CYC)) u_props (.*);

// ==== bench/tb_dram_page_ctrl.sv ====
// self-checking bench for the page-mode dram controller
module tb_dram_page_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 30000;
    localparam int PWR = 50;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_req_valid = 1'b0;
    logic [1:0] i_req_op = 2'h0;
    logic [19:0] i_req_addr = 20'h0;
    logic [3:0] i_req_wdata = 4'h0;
    wire ready, rvalid, init_done, row_n, col_n, we_n, oe_n, d_oe;
    wire [3:0] rdata, d_out, dq;
    wire [9:0] addr;
    logic [3:0] exp_mem [bit [19:0]];
    logic [19:0] corner [4] = '{20'h00000, 20'h003ff, 20'h00400, 20'hfffff};
    logic [1:0] ops [5] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h0};
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int row_falls = 0;
    int n;
    int wakes = 0;
    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;
    always @(negedge row_n) row_falls++;
    // drops of init done after reset mark a repeated wakeup
    always @(negedge init_done) if (!i_reset) wakes++;
    dram_page_ctrl #(.POWERUP_CYC(PWR), .IDLE_CYC(300), .REFRESH_CYC(500),
        .PAGE_MAX_CYC(2000)) DUT (.i_clk(i_clk), .i_reset(i_reset),
        .i_ce(1'b1), .i_req_valid(i_req_valid), .o_req_ready(ready),
        .i_req_op(i_req_op), .i_req_addr(i_req_addr),
        .i_req_wdata(i_req_wdata), .o_rdata(rdata), .o_rdata_valid(rvalid),
        .o_init_done(init_done), .o_row_strobe_n(row_n),
        .o_col_strobe_n(col_n), .o_write_n(we_n), .o_out_enable_n(oe_n),
        .o_muxed_address_lines(addr), .i_data_lines(dq),
        .o_data_lines(d_out), .o_data_lines_oe(d_oe));
    dram_model u_mem (.row_n(row_n), .col_n(col_n), .write_n(we_n),
        .oe_n(oe_n), .addr(addr), .d_ctrl(d_out), .d_oe(d_oe), .line(dq));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [3:0] exp_read(input logic [19:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : 4'h0;
    endfunction
    task automatic check(input string what, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one request held until taken; reads wait for their data
    task automatic access(input logic [1:0] op, input logic [19:0] a,
        input logic [3:0] wd);
        logic [3:0] e;
        int k;
        e = exp_read(a);
        @(negedge i_clk);
        i_req_valid = 1'b1;
        i_req_op = op;
        i_req_addr = a;
        i_req_wdata = wd;
        k = 0;
        while (ready !== 1'b1 && k < 3000) begin
            @(negedge i_clk);
            k++;
        end
        @(negedge i_clk);
        i_req_valid = 1'b0;
        if (op == 2'h0 || op == 2'h3) begin
            k = 0;
            while (rvalid !== 1'b1 && k < 64) begin
                @(negedge i_clk);
                k++;
            end
            check("read_data", e, rdata);
        end
        if (op != 2'h0)
            exp_mem[a] = wd;
    endtask
    // hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        void'($urandom(74));
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        n = 0;
        while (init_done !== 1'b1 && n < 5000) begin
            @(negedge i_clk);
            n++;
        end
        check("powerup_wait", 1, n >= PWR);
        check("wake_cycles", 1, row_falls >= 8);
        $display("test init end");
        foreach (corner[c])
            foreach (ops[i])
                access(ops[i], corner[c], 4'(c * 5 + i));
        $display("test corners end");
        repeat (60)
            access(2'($urandom), {9'h0, 1'($urandom), 10'($urandom)},
                4'($urandom));
        $display("test random end");
        n = row_falls;
        repeat (5500) @(negedge i_clk);
        check("wakeup_seen", 1, wakes > 0);
        check("refresh_rows", 1, row_falls - n >= 10);
        foreach (corner[c])
            access(2'h0, corner[c], 4'h0);
        $display("test idle end");
        conclude();
    end
endmodule // tb_dram_page_ctrl
